// ==== hdl/erh_params.svh ====
`ifndef ERH_PARAMS_SVH
`define ERH_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define ERH_OFS_CTRL      8'h00
`define ERH_OFS_FUNC_EN   8'h04
`define ERH_OFS_RID_BASE  8'h08
`define ERH_OFS_RP_TAG    8'h0c
`define ERH_OFS_STATUS    8'h10
`define ERH_OFS_PORT_AER  8'h14
`define ERH_OFS_FUNC_LOG  8'h18
`define ERH_OFS_COR_CNT   8'h1c
`define ERH_OFS_PSN_CNT   8'h20

////////////////////////////////////////////////////////////////////////////////
// control register fields
`define ERH_CTRL_REPORT_EN   0
`define ERH_CTRL_NF_AER      1
`define ERH_CTRL_FATAL_BCAST 2
`define ERH_CTRL_PSN_TRACK   3
`define ERH_CTRL_PSN_MSI     4
`define ERH_CTRL_TO_COLL     5

////////////////////////////////////////////////////////////////////////////////
// status register fields
`define ERH_STS_COR      0
`define ERH_STS_REC      1
`define ERH_STS_NF       2
`define ERH_STS_FATAL    3
`define ERH_STS_SCRUB    4
`define ERH_STS_PSN_RX   5
`define ERH_STS_NONFUNC  6
`define ERH_STS_BCAST    7

////////////////////////////////////////////////////////////////////////////////
// device message cause fields
`define ERH_MSI_COR      0
`define ERH_MSI_REC      1
`define ERH_MSI_NF       2
`define ERH_MSI_SCRUB    3
`define ERH_MSI_PSN      4

////////////////////////////////////////////////////////////////////////////////
// reset values
`define ERH_RST_CTRL     6'h00
`define ERH_RST_FUNC_EN  12'h000
`define ERH_RST_RID_BASE 16'h0000
`define ERH_RST_RP_TAG   8'h01

`endif

// ==== hdl/erh_pkg.sv ====
package erh_pkg;

	typedef enum logic [1:0] {
		ERH_SEV_COR,
		ERH_SEV_NF,
		ERH_SEV_FATAL
	} erh_sev_t;

	typedef enum logic {
		ERH_KIND_CORRECTABLE_INTERNAL,
		ERH_KIND_UNCORRECTABLE_INTERNAL
	} erh_kind_t;

	// detected error event, one cycle
	typedef struct packed {
		logic       cor;
		logic       rec;
		logic       nf;
		logic       fatal;
		logic       scrub;
		logic       nonfunc;
		logic       from_root_port;
		logic [1:0] func;
	} erh_evt_t;

	// demand read from local memory
	typedef struct packed {
		logic        valid;
		logic        uc_err;
		logic [31:0] data;
	} erh_rd_t;

	// demand read answer
	typedef struct packed {
		logic        valid;
		logic        poison;
		logic [31:0] data;
	} erh_rdo_t;

	// data received from the host on any protocol
	typedef struct packed {
		logic        valid;
		logic [1:0]  proto;
		logic        poison;
		logic [31:0] data;
	} erh_rxp_t;

	// write into local storage
	typedef struct packed {
		logic        valid;
		logic        poison;
		logic [31:0] data;
	} erh_sto_t;

	// error message on the i/o protocol path
	typedef struct packed {
		logic       valid;
		erh_kind_t  kind;
		erh_sev_t   sev;
		logic [15:0] rid;
		logic [7:0] tag;
		logic       to_collector;
	} erh_msg_t;

	typedef struct packed {
		logic [5:0]  ctrl;
		logic [11:0] func_en;
		logic [15:0] rid_base;
		logic [7:0]  rp_tag;
		logic [7:0]  sts;
		logic [2:0]  port_aer;
		logic [11:0] func_log;
		logic [15:0] cor_cnt;
		logic [15:0] psn_cnt;
		logic [1:0]  last_proto;
		logic [2:0]  pend;
		logic [2:0]  pend_rp;
		logic [4:0]  msi_pend;
		logic        msi_valid;
		logic [4:0]  msi_cause;
		erh_msg_t    msg;
		erh_rdo_t    rdo;
		erh_sto_t    sto;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} erh_state_t;

endpackage : erh_pkg

// ==== hdl/erh_top.sv ====
`timescale 1ns/100ps
`include "erh_params.svh"

module erh_top
	import erh_pkg::*;
(
	// clock and resets
	input  wire logic        i_mclk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_warm_rst,
	// apb slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic             o_pready,
	output logic             o_pslverr,
	output logic [31:0]      o_prdata,
	// error events and data paths
	input  wire erh_evt_t    i_evt,
	input  wire erh_rd_t     i_rd,
	input  wire erh_rxp_t    i_rxp,
	output erh_rdo_t         o_rdo,
	output erh_sto_t         o_sto,
	// device message to the driver
	input  wire logic        i_msi_ready,
	output logic             o_msi_valid,
	output logic [4:0]       o_msi_cause,
	// error message toward the host
	input  wire logic        i_msg_ready,
	output erh_msg_t         o_msg,
	// containment broadcast status
	output logic             o_contain_bcast
);

	////////////////////////////////////////////////////////////////////////////
	// decode helpers

	function automatic logic reg_hit(input logic [7:0] a);
		reg_hit = (a == `ERH_OFS_CTRL) || (a == `ERH_OFS_FUNC_EN) || (a == `ERH_OFS_RID_BASE) ||
			(a == `ERH_OFS_RP_TAG) || (a == `ERH_OFS_STATUS) || (a == `ERH_OFS_PORT_AER) ||
			(a == `ERH_OFS_FUNC_LOG) || (a == `ERH_OFS_COR_CNT) || (a == `ERH_OFS_PSN_CNT);
	endfunction : reg_hit

	// lowest function enabled to send a message of this severity
	function automatic logic [2:0] pick_fn(input logic [11:0] en, input logic [1:0] sev);
		logic [3:0] row;
		row = en[4*sev +: 4];
		if (row[0]) begin
			pick_fn = 3'b100;
		end else if (row[1]) begin
			pick_fn = 3'b101;
		end else if (row[2]) begin
			pick_fn = 3'b110;
		end else if (row[3]) begin
			pick_fn = 3'b111;
		end else begin
			pick_fn = 3'b000;
		end
	endfunction : pick_fn

	function automatic erh_state_t cold_state();
		erh_state_t c;
		c = '0;
		c.ctrl = `ERH_RST_CTRL;
		c.func_en = `ERH_RST_FUNC_EN;
		c.rid_base = `ERH_RST_RID_BASE;
		c.rp_tag = `ERH_RST_RP_TAG;
		cold_state = c;
	endfunction : cold_state

	erh_state_t s_q;
	erh_state_t s_d;

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic        acc;
		logic        wr;
		logic [31:0] rdv;
		logic        en;
		logic [2:0]  sev_set;
		logic [2:0]  rp_set;
		logic [4:0]  msi_set;
		logic [7:0]  sts_set;
		logic [2:0]  aer_set;
		logic [11:0] flog_set;
		logic [2:0]  fsev;
		logic        psn_bad;
		logic        psn_ok;
		logic [2:0]  taken;
		logic [2:0]  pk;
		logic [1:0]  sidx;
		acc = 1'b0;
		wr = 1'b0;
		rdv = 32'h0000_0000;
		en = 1'b0;
		sev_set = 3'b000;
		rp_set = 3'b000;
		msi_set = 5'h00;
		sts_set = 8'h00;
		aer_set = 3'b000;
		flog_set = 12'h000;
		fsev = 3'b000;
		psn_bad = 1'b0;
		psn_ok = 1'b0;
		taken = 3'b000;
		pk = 3'b000;
		sidx = 2'b00;
		s_d = s_q;

		// apb: one wait state, write lands on the edge that sees pready
		acc = i_psel && i_penable;
		wr = acc && s_q.pready && i_pwrite;
		s_d.pready = 1'b0;
		s_d.pslverr = 1'b0;
		if (i_paddr == `ERH_OFS_CTRL) begin
			rdv = {26'h0, s_q.ctrl};
		end else if (i_paddr == `ERH_OFS_FUNC_EN) begin
			rdv = {20'h0, s_q.func_en};
		end else if (i_paddr == `ERH_OFS_RID_BASE) begin
			rdv = {16'h0, s_q.rid_base};
		end else if (i_paddr == `ERH_OFS_RP_TAG) begin
			rdv = {24'h0, s_q.rp_tag};
		end else if (i_paddr == `ERH_OFS_STATUS) begin
			rdv = {22'h0, s_q.last_proto, s_q.sts};
		end else if (i_paddr == `ERH_OFS_PORT_AER) begin
			rdv = {29'h0, s_q.port_aer};
		end else if (i_paddr == `ERH_OFS_FUNC_LOG) begin
			rdv = {20'h0, s_q.func_log};
		end else if (i_paddr == `ERH_OFS_COR_CNT) begin
			rdv = {16'h0, s_q.cor_cnt};
		end else if (i_paddr == `ERH_OFS_PSN_CNT) begin
			rdv = {16'h0, s_q.psn_cnt};
		end
		if (acc && !s_q.pready) begin
			s_d.pready = 1'b1;
			s_d.pslverr = !reg_hit(i_paddr);
			s_d.prdata = i_pwrite ? 32'h0000_0000 : rdv;
		end

		// software selects the options before reporting starts
		if (wr && i_paddr == `ERH_OFS_CTRL) begin
			s_d.ctrl = i_pwdata[5:0];
		end else if (wr && i_paddr == `ERH_OFS_FUNC_EN) begin
			s_d.func_en = i_pwdata[11:0];
		end else if (wr && i_paddr == `ERH_OFS_RID_BASE) begin
			s_d.rid_base = i_pwdata[15:0];
		end else if (wr && i_paddr == `ERH_OFS_RP_TAG) begin
			s_d.rp_tag = i_pwdata[7:0];
		end else if (wr && i_paddr == `ERH_OFS_STATUS) begin
			s_d.sts = s_q.sts & ~i_pwdata[7:0];
		end else if (wr && i_paddr == `ERH_OFS_PORT_AER) begin
			s_d.port_aer = s_q.port_aer & ~i_pwdata[2:0];
		end else if (wr && i_paddr == `ERH_OFS_FUNC_LOG) begin
			s_d.func_log = s_q.func_log & ~i_pwdata[11:0];
		end else if (wr && i_paddr == `ERH_OFS_COR_CNT) begin
			s_d.cor_cnt = 16'h0000;
		end else if (wr && i_paddr == `ERH_OFS_PSN_CNT) begin
			s_d.psn_cnt = 16'h0000;
		end

		// demand read: poison the answer, raise no report
		s_d.rdo.valid = i_rd.valid;
		s_d.rdo.poison = i_rd.valid && i_rd.uc_err;
		s_d.rdo.data = i_rd.uc_err ? 32'h0000_0000 : i_rd.data;

		// received data: poison is never stored as good data
		psn_ok = i_rxp.valid && i_rxp.poison && s_q.ctrl[`ERH_CTRL_PSN_TRACK];
		psn_bad = i_rxp.valid && i_rxp.poison && !s_q.ctrl[`ERH_CTRL_PSN_TRACK];
		s_d.sto.valid = i_rxp.valid && !psn_bad;
		s_d.sto.poison = i_rxp.poison;
		s_d.sto.data = i_rxp.data;
		if (i_rxp.valid && i_rxp.poison) begin
			s_d.last_proto = i_rxp.proto;
		end

		// classify detected errors
		en = s_q.ctrl[`ERH_CTRL_REPORT_EN];
		if (en) begin
			sts_set[`ERH_STS_COR] = i_evt.cor;
			sts_set[`ERH_STS_REC] = i_evt.rec;
			sts_set[`ERH_STS_NF] = i_evt.nf || psn_bad;
			sts_set[`ERH_STS_FATAL] = i_evt.fatal;
			sts_set[`ERH_STS_SCRUB] = i_evt.scrub;
			sts_set[`ERH_STS_PSN_RX] = i_rxp.valid && i_rxp.poison;
			sts_set[`ERH_STS_NONFUNC] = i_evt.nonfunc && (i_evt.cor || i_evt.nf || i_evt.fatal);
			sts_set[`ERH_STS_BCAST] = i_evt.fatal && s_q.ctrl[`ERH_CTRL_FATAL_BCAST];
			msi_set[`ERH_MSI_COR] = i_evt.cor && !i_evt.nonfunc;
			msi_set[`ERH_MSI_REC] = i_evt.rec;
			msi_set[`ERH_MSI_NF] = i_evt.nf && !i_evt.nonfunc && !s_q.ctrl[`ERH_CTRL_NF_AER];
			msi_set[`ERH_MSI_SCRUB] = i_evt.scrub;
			msi_set[`ERH_MSI_PSN] = psn_ok && s_q.ctrl[`ERH_CTRL_PSN_MSI];
			sev_set[ERH_SEV_COR] = i_evt.cor && i_evt.nonfunc;
			sev_set[ERH_SEV_NF] = (i_evt.nf && (i_evt.nonfunc || s_q.ctrl[`ERH_CTRL_NF_AER])) ||
				psn_bad;
			sev_set[ERH_SEV_FATAL] = i_evt.fatal;
			rp_set = i_evt.from_root_port ? (sev_set & {1'b1, !psn_bad, 1'b1}) : 3'b000;
			fsev = {i_evt.fatal, i_evt.nf, i_evt.cor};
			if (i_evt.nonfunc) begin
				aer_set = fsev;
			end
			for (int f = 0; f < 4; f++) begin
				for (int v = 0; v < 3; v++) begin
					flog_set[4*v+f] = fsev[v] && (i_evt.nonfunc || i_evt.func == f[1:0]);
				end
			end
		end

		// sticky logs: set wins over a clear in the same cycle
		s_d.sts = s_d.sts | sts_set;
		s_d.port_aer = s_d.port_aer | aer_set;
		s_d.func_log = s_d.func_log | flog_set;
		if (en && i_evt.cor && s_d.cor_cnt != 16'hffff) begin
			s_d.cor_cnt = s_d.cor_cnt + 16'h0001;
		end
		if (en && i_rxp.valid && i_rxp.poison && s_d.psn_cnt != 16'hffff) begin
			s_d.psn_cnt = s_d.psn_cnt + 16'h0001;
		end

		// device message toward the driver
		if (!s_q.msi_valid || i_msi_ready) begin
			s_d.msi_valid = |s_q.msi_pend;
			s_d.msi_cause = s_q.msi_pend;
			s_d.msi_pend = 5'h00;
		end
		s_d.msi_pend = s_d.msi_pend | msi_set;

		// one pending message per severity; later ones merge into it
		if (!s_q.msg.valid || i_msg_ready) begin
			s_d.msg.valid = 1'b0;
			if (s_q.pend[ERH_SEV_FATAL]) begin
				sidx = 2'(ERH_SEV_FATAL);
			end else if (s_q.pend[ERH_SEV_NF]) begin
				sidx = 2'(ERH_SEV_NF);
			end else begin
				sidx = 2'(ERH_SEV_COR);
			end
			if (|s_q.pend) begin
				taken[sidx] = 1'b1;
				pk = pick_fn(s_q.func_en, sidx);
				s_d.msg.valid = pk[2];
				s_d.msg.sev = erh_sev_t'(sidx);
				s_d.msg.kind = (sidx == 2'(ERH_SEV_COR)) ? ERH_KIND_CORRECTABLE_INTERNAL :
					ERH_KIND_UNCORRECTABLE_INTERNAL;
				s_d.msg.rid = s_q.rid_base + {14'h0, pk[1:0]};
				s_d.msg.tag = !s_q.pend_rp[sidx] ? 8'h00 :
					(s_q.rp_tag == 8'h00 ? 8'h01 : s_q.rp_tag);
				s_d.msg.to_collector = s_q.ctrl[`ERH_CTRL_TO_COLL];
			end
		end
		s_d.pend = (s_q.pend & ~taken) | sev_set;
		s_d.pend_rp = (s_q.pend_rp & ~taken) | rp_set;

		// warm reset keeps only the logs
		if (i_warm_rst) begin
			s_d = cold_state();
			s_d.sts = s_q.sts;
			s_d.port_aer = s_q.port_aer;
			s_d.func_log = s_q.func_log;
			s_d.cor_cnt = s_q.cor_cnt;
			s_d.psn_cnt = s_q.psn_cnt;
			s_d.last_proto = s_q.last_proto;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			s_q <= cold_state();
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign o_pready = s_q.pready;
	assign o_pslverr = s_q.pslverr;
	assign o_prdata = s_q.prdata;
	assign o_rdo = s_q.rdo;
	assign o_sto = s_q.sto;
	assign o_msi_valid = s_q.msi_valid;
	assign o_msi_cause = s_q.msi_cause;
	assign o_msg = s_q.msg;
	assign o_contain_bcast = s_q.sts[`ERH_STS_BCAST];

endmodule : erh_top

// ==== verification/erh_host_model.sv ====
`timescale 1ns/100ps
module erh_host_model
	import erh_pkg::*;
(
	// clock and reset
	input  wire logic       i_mclk,
	input  wire logic       i_sys_rst,
	input  wire logic       i_slow,
	// traffic from the device
	input  wire erh_msg_t   i_msg,
	input  wire logic       i_msi_valid,
	input  wire logic [4:0] i_msi_cause,
	// answers and record
	output logic            o_msg_ready,
	output logic            o_msi_ready,
	output logic [7:0]      o_msg_cnt,
	output logic [7:0]      o_msi_cnt,
	output erh_msg_t        o_last_msg,
	output logic [4:0]      o_last_cause
);
	logic [1:0] ctr_q;
	// ready each cycle, or one cycle in four when slow
	assign o_msg_ready = !i_slow || ctr_q == 2'h3;
	assign o_msi_ready = !i_slow || ctr_q == 2'h3;
	// one collector takes every message
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ctr_q <= 2'h0;
			o_msg_cnt <= 8'h00;
			o_msi_cnt <= 8'h00;
			o_last_msg <= '0;
			o_last_cause <= 5'h00;
		end else begin
			ctr_q <= ctr_q + 2'h1;
			if (i_msg.valid && o_msg_ready) begin
				o_msg_cnt <= o_msg_cnt + 8'h01;
				o_last_msg <= i_msg;
			end
			if (i_msi_valid && o_msi_ready) begin
				o_msi_cnt <= o_msi_cnt + 8'h01;
				o_last_cause <= i_msi_cause;
			end
		end
	end
endmodule : erh_host_model

// ==== verification/erh_top_monitor.sv ====
`timescale 1ns/100ps
module erh_top_monitor
	import erh_pkg::*;
(
	input wire logic        i_mclk,
	input wire logic        i_sys_rst,
	input wire logic        i_warm_rst,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [7:0]  i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic [31:0] o_prdata,
	input wire erh_evt_t    i_evt,
	input wire erh_rd_t     i_rd,
	input wire erh_rxp_t    i_rxp,
	input wire erh_rdo_t    o_rdo,
	input wire erh_sto_t    o_sto,
	input wire logic        i_msi_ready,
	input wire logic        o_msi_valid,
	input wire logic [4:0]  o_msi_cause,
	input wire logic        i_msg_ready,
	input wire erh_msg_t    o_msg,
	input wire logic        o_contain_bcast
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst || i_warm_rst);
	chk_rd_poison: assert property (i_rd.valid |=> o_rdo.valid && o_rdo.poison == $past(i_rd.uc_err))
		else $error("demand read poison flag wrong");
	chk_rd_good: assert property (i_rd.valid && !i_rd.uc_err |=> o_rdo.data == $past(i_rd.data))
		else $error("demand read data wrong");
	chk_sto_good: assert property (i_rxp.valid && !i_rxp.poison |=> o_sto.valid && !o_sto.poison)
		else $error("clean data not stored");
	chk_sto_psn: assert property (i_rxp.valid && i_rxp.poison |=> !o_sto.valid || o_sto.poison)
		else $error("poison stored as good");
	chk_msg_hold: assert property (o_msg.valid && !i_msg_ready |=> o_msg.valid && $stable(o_msg))
		else $error("message dropped before ready");
	chk_msi_hold: assert property (o_msi_valid && !i_msi_ready |=> o_msi_valid && $stable(o_msi_cause))
		else $error("device message dropped");
	chk_msg_kind: assert property (o_msg.valid |->
		(o_msg.sev == ERH_SEV_COR) == (o_msg.kind == ERH_KIND_CORRECTABLE_INTERNAL))
		else $error("message kind wrong");
	chk_bcast_src: assert property ($rose(o_contain_bcast) |-> $past(i_evt.fatal))
		else $error("broadcast without fatal");
	chk_apb_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
		else $error("apb answer late");
	chk_warm_quiet: assert property (@(posedge i_mclk) disable iff (i_sys_rst) i_warm_rst |=> !o_msg.valid && !o_msi_valid)
		else $error("output left up in warm reset");
	cover property (o_msg.valid && i_msg_ready);
	cover property (o_msi_valid && i_msi_ready);
	cover property (i_rd.valid && i_rd.uc_err);
endmodule : erh_top_monitor
bind erh_top erh_top_monitor erh_top_monitor_i (.*);

// ==== verification/erh_top_tb.sv ====
`timescale 1ns/100ps
`define CHK(n,e,g) begin num_checks++; if ((g)!==(e)) begin n_mismatch++; $display("CHECK FAILED %s exp %0h got %0h",n,e,g); end end
module erh_top_tb
	import erh_pkg::*;
;
	logic        clk, rst, warm, psel, pen, pwr, rdy, err, mir, miv, mgr, bc, slow, er;
	logic [7:0]  addr, em, es, nmsg, nmsi;
	logic [31:0] wd, prd, rv;
	logic [4:0]  mic, lcause;
	erh_evt_t    evt;
	erh_rd_t     rd;
	erh_rxp_t    rxp;
	erh_rdo_t    rdo;
	erh_sto_t    sto;
	erh_msg_t    msg, lmsg;
	int          n_mismatch, num_checks;
	erh_top erh_top_i (.i_mclk(clk), .i_sys_rst(rst), .i_warm_rst(warm), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd), .o_pready(rdy), .o_pslverr(err), .o_prdata(prd),
		.i_evt(evt), .i_rd(rd), .i_rxp(rxp), .o_rdo(rdo), .o_sto(sto), .i_msi_ready(mir), .o_msi_valid(miv),
		.o_msi_cause(mic), .i_msg_ready(mgr), .o_msg(msg), .o_contain_bcast(bc));
	erh_host_model erh_host_model_i (.i_mclk(clk), .i_sys_rst(rst), .i_slow(slow), .i_msg(msg),
		.i_msi_valid(miv), .i_msi_cause(mic), .o_msg_ready(mgr), .o_msi_ready(mir), .o_msg_cnt(nmsg),
		.o_msi_cnt(nmsi), .o_last_msg(lmsg), .o_last_cause(lcause));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task summarize;
		$display("mismatches %0d checks %0d", n_mismatch, num_checks);
		if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : summarize
	////////////////////////////////////////////////////////////////////////////
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		addr <= a;
		wd <= d;
		@(posedge clk);
		pen <= 1'b1;
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (rdy !== 1'b1 && k < 50);
		if (k >= 50) n_mismatch++;
		if (k >= 50) summarize();
		rv = prd;
		er = err;
		@(posedge clk);
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK("reg", e, rv)
	endtask : rchk
	task automatic ev(input erh_evt_t e, input int n);
		@(posedge clk);
		evt <= e;
		repeat (n) @(posedge clk);
		evt <= '0;
	endtask : ev
	task automatic wcnt;
		int k;
		k = 0;
		while ((nmsg !== em || nmsi !== es) && k < 40) begin
			@(posedge clk);
			k++;
		end
		repeat (8) @(posedge clk);
		`CHK("msgs", em, nmsg)
		`CHK("msis", es, nmsi)
	endtask : wcnt
	task automatic rx(input logic [1:0] p, input logic ps);
		@(posedge clk);
		rxp <= {1'b1, p, ps, 32'h0000beef};
		@(posedge clk);
		rxp <= '0;
		@(negedge clk);
	endtask : rx
	////////////////////////////////////////////////////////////////////////////
	task automatic s_reset;
		rchk(8'h00, 32'h0);
		rchk(8'h0c, 32'h1);
		rchk(8'h24, 32'h0);
		`CHK("slverr", 1'b1, er)
	endtask : s_reset
	task automatic s_demand;
		apb(1'b1, 8'h00, 32'h1);
		apb(1'b1, 8'h04, 32'hfff);
		@(posedge clk);
		rd <= {1'b1, 1'b1, 32'h00001234};
		@(posedge clk);
		rd <= '0;
		@(negedge clk);
		`CHK("rdo", {1'b1, 1'b1, 32'h0}, rdo)
		wcnt();
	endtask : s_demand
	task automatic s_msi;
		erh_evt_t   te [4] = '{9'h101, 9'h080, 9'h010, 9'h040};
		logic [4:0] tc [4] = '{5'h01, 5'h02, 5'h08, 5'h04};
		for (int i = 0; i < 4; i++) begin
			ev(te[i], 1);
			es = es + 8'h01;
			wcnt();
			`CHK("cause", tc[i], lcause)
		end
		rchk(8'h1c, 32'h1);
	endtask : s_msi
	task automatic s_msg;
		apb(1'b1, 8'h08, 32'h100);
		apb(1'b1, 8'h04, 32'h4ff);
		apb(1'b1, 8'h00, 32'h7);
		ev(9'h040, 1);
		em = em + 8'h01;
		wcnt();
		`CHK("nf", {1'b1, ERH_KIND_UNCORRECTABLE_INTERNAL, ERH_SEV_NF, 16'h0100, 8'h0, 1'b0}, lmsg)
		ev(9'h022, 1);
		em = em + 8'h01;
		wcnt();
		`CHK("fatal", {1'b1, ERH_KIND_UNCORRECTABLE_INTERNAL, ERH_SEV_FATAL, 16'h0102, 8'h0, 1'b0}, lmsg)
		`CHK("bcast", 1'b1, bc)
	endtask : s_msg
	task automatic s_merge;
		apb(1'b1, 8'h0c, 32'h5);
		apb(1'b1, 8'h00, 32'h27);
		slow <= 1'b1;
		// second cycle of the event lands in the same cycle the first is taken: one more message
		ev(9'h026, 2);
		em = em + 8'h02;
		wcnt();
		`CHK("rp", {1'b1, ERH_KIND_UNCORRECTABLE_INTERNAL, ERH_SEV_FATAL, 16'h0102, 8'h5, 1'b1}, lmsg)
		slow <= 1'b0;
	endtask : s_merge
	task automatic s_nonfunc;
		apb(1'b1, 8'h18, 32'hfff);
		apb(1'b1, 8'h04, 32'h00f);
		ev(9'h048, 1);
		wcnt();
		rchk(8'h14, 32'h2);
		rchk(8'h18, 32'h0f0);
		apb(1'b1, 8'h04, 32'h020);
		ev(9'h048, 1);
		em = em + 8'h01;
		wcnt();
		`CHK("nfn", {1'b1, ERH_KIND_UNCORRECTABLE_INTERNAL, ERH_SEV_NF, 16'h0101, 8'h0, 1'b1}, lmsg)
	endtask : s_nonfunc
	task automatic s_poison;
		apb(1'b1, 8'h00, 32'h01);
		rx(2'h1, 1'b1);
		`CHK("drop", 1'b0, sto.valid)
		em = em + 8'h01;
		wcnt();
		`CHK("psn", {1'b1, ERH_KIND_UNCORRECTABLE_INTERNAL, ERH_SEV_NF, 16'h0101, 8'h0, 1'b0}, lmsg)
		apb(1'b1, 8'h00, 32'h19);
		for (int p = 0; p < 3; p++) begin
			rx(p[1:0], 1'b1);
			`CHK("sto", 2'b11, {sto.valid, sto.poison})
			es = es + 8'h01;
			wcnt();
			`CHK("pcause", 5'h10, lcause)
			apb(1'b0, 8'h10, 32'h0);
			`CHK("proto", p[1:0], rv[9:8])
		end
	endtask : s_poison
	task automatic s_warm;
		@(posedge clk);
		warm <= 1'b1;
		repeat (2) @(posedge clk);
		warm <= 1'b0;
		rchk(8'h00, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		`CHK("sticky", 3'b101, {rv[9:8], rv[5]})
	endtask : s_warm
	////////////////////////////////////////////////////////////////////////////
	initial begin
		{rst, warm, psel, pen, pwr, slow} = 6'h21;
		{addr, wd, evt, rd, rxp, em, es} = '0;
		n_mismatch = 0;
		num_checks = 0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		s_reset();
		s_demand();
		s_msi();
		s_msg();
		s_merge();
		s_nonfunc();
		s_poison();
		s_warm();
		summarize();
	end
endmodule : erh_top_tb
